/* File: bench/adc_touch_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_touch_asserts
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        start_pulse,
  input wire logic        calib_run,
  input wire logic        touch_slot,
  input wire logic        resolution_select,
  input wire logic        core_power,
  input wire logic [4:0]  sample_periods,
  input wire logic        sequence_order_select
);
  logic wp_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ------
  // Protection shadow, cleared by soft reset too
  // ------
  always_ff @(posedge clk)
    if (reset || (wr && addr == 8'h00 && wdata[0]))
      wp_q <= 1'b0;
    else if (wr && addr == 8'hE4)
      wp_q <= wdata[0];

  // ------
  // Properties
  // ------
  property p_start;
    wr && addr == 8'h00 && wdata[1:0] == 2'b10 |=> start_pulse;
  endproperty
  a_start: assert property (p_start)
    else $error("start write gave no start pulse");

  property p_rd_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");

  property p_reserved;
    rd && (addr == 8'h0C || addr == 8'h1C || addr >= 8'hEC) |=> rdata == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved offset read nonzero");

  property p_wp_clear;
    (rd && addr == 8'hE8) ##1 !wr ##1 (rd && addr == 8'hE8) |=> !rdata[0];
  endproperty
  a_wp_clear: assert property (p_wp_clear)
    else $error("violation flag survived status read");

  property p_mode_wr;
    wr && addr == 8'h04 && !wp_q |-> ##2 resolution_select == $past(wdata[4], 2)
      && sequence_order_select == $past(wdata[31], 2);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode write not applied");

  property p_mode_block;
    wr && addr == 8'h04 && wp_q |=> ##1 $stable(resolution_select) && $stable(sample_periods);
  endproperty
  a_mode_block: assert property (p_mode_block)
    else $error("protected mode write took effect");

  property p_track;
    wr && addr == 8'h04 && !wp_q |-> ##2 sample_periods == {1'b0, $past(wdata[27:24], 2)} + 5'd1;
  endproperty
  a_track: assert property (p_track)
    else $error("sample time not field plus one");

  property p_srst;
    wr && addr == 8'h00 && wdata[0] |-> ##[1:3] (!resolution_select && sample_periods == 5'd1
      && core_power);
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset did not restore defaults");

  c_touch: cover property (start_pulse && touch_slot);
  c_calib: cover property (calib_run);
  c_block: cover property (wr && addr == 8'h04 && wp_q);
endmodule

bind adc_touch_buffer_and_regs adc_touch_asserts chk_u
(
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .start_pulse(start_pulse), .calib_run(calib_run), .touch_slot(touch_slot),
  .resolution_select(resolution_select), .core_power(core_power),
  .sample_periods(sample_periods), .sequence_order_select(sequence_order_select)
);
`default_nettype wire

/* File: bench/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model
  import adc_touch_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start_pulse,
  input  wire logic       touch_slot,
  input  wire logic       calib_run,
  output logic            result_valid,
  output logic [1:0]      result_kind,
  output logic [3:0]      result_chan,
  output logic [9:0]      result_data,
  output logic            seq_done
);
  logic slow_q = 1'b0;
  logic ts;
  logic cal;

  // ------
  // One result word; slow sequences stretch the gaps
  // ------
  task automatic put(input result_kind_e k, input logic [3:0] c, input logic [9:0] d);
    repeat (slow_q ? 6 : 1) @(posedge clk);
    result_valid <= 1'b1;
    result_kind  <= k;
    result_chan  <= c;
    result_data  <= d;
    @(posedge clk);
    result_valid <= 1'b0;
    result_data  <= ~d;
  endtask

  initial
  begin
    result_valid = 1'b0;
    result_kind  = 2'h0;
    result_chan  = 4'h0;
    result_data  = 10'h0;
    seq_done     = 1'b0;
  end

  always
  begin
    @(posedge clk);
    if (start_pulse === 1'b1 && !reset)
    begin
      @(posedge clk);
      ts = touch_slot;
      cal = calib_run;
      if (cal)
        put(res_x, 4'h0, 10'h3FF);
      else
        put(res_classic, 4'h4, 10'h2A5);
      if (ts && !cal)
      begin
        put(res_x, 4'h0, 10'h111);
        put(res_y, 4'h1, 10'h222);
        put(res_z, 4'h0, 10'h033);
        put(res_z, 4'h1, 10'h044);
      end
      seq_done <= 1'b1;
      @(posedge clk);
      seq_done <= 1'b0;
      slow_q   <= ~slow_q;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %0h want %0h", $time, g, e); end end
module tb_top;
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        clk, reset, wr, rd, trigger, live_contact_flag, result_valid, seq_done;
  logic        start_pulse, calib_run, touch_slot, resolution_select, core_power;
  logic        sequence_order_select, converter_clock, s, c;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  result_kind;
  logic [3:0]  result_chan, sl;
  logic [9:0]  result_data, startup_periods;
  logic [4:0]  sample_periods;
  int          fails = 0, comparisons = 0, k, p, e;
  int          sut[16] = '{0, 8, 16, 24, 64, 80, 96, 112, 512, 576, 640, 704, 768, 832, 896, 960};
  logic [7:0]  prot[9] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h40, 8'h44, 8'h94, 8'hB0, 8'hC0};
  row_s        rows[13] = '{'{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
    '{1'b0, 8'h94, 32'h0, 32'h0000_0100}, '{1'b0, 8'hB0, 32'h0, 32'h0},
    '{1'b0, 8'hC0, 32'h0, 32'h0}, '{1'b0, 8'hE4, 32'h0, 32'h0}, '{1'b0, 8'hE8, 32'h0, 32'h0},
    '{1'b0, 8'h1C, 32'h0, 32'h0}, '{1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0},
    '{1'b1, 8'h08, 32'h0000_3210, 32'h0000_3210}, '{1'b1, 8'h04, 32'h8A05_3C20, 32'h8A05_3C20}};

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  adc_touch_buffer_and_regs dut_u
  (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger(trigger), .live_contact_flag(live_contact_flag), .result_valid(result_valid),
    .result_kind(result_kind), .result_chan(result_chan), .result_data(result_data),
    .seq_done(seq_done), .start_pulse(start_pulse), .calib_run(calib_run),
    .touch_slot(touch_slot), .resolution_select(resolution_select), .core_power(core_power),
    .sample_hold_time_field_x(), .sample_periods(sample_periods),
    .sequence_order_select(sequence_order_select), .startup_periods(startup_periods),
    .converter_clock(converter_clock)
  );

  core_model model_u
  (
    .clk(clk), .reset(reset), .start_pulse(start_pulse), .touch_slot(touch_slot),
    .calib_run(calib_run), .result_valid(result_valid), .result_kind(result_kind),
    .result_chan(result_chan), .result_data(result_data), .seq_done(seq_done)
  );

  // ------
  // Bus, trigger and verdict tasks
  // ------
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic wait_hi(input bit w);
    int n;
    for (n = 0; n < 200; n++)
    begin
      #1;
      if ((w ? seq_done : start_pulse) === 1'b1)
        break;
      @(posedge clk);
    end
    if (n == 200)
    begin
      fails++;
      results();
    end
  endtask

  // Leaves the last result word in r
  task automatic trig();
    trigger <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    wait_hi(0);
    @(posedge clk);
    #1;
    s = touch_slot;
    c = calib_run;
    wait_hi(1);
    repeat (3) @(posedge clk);
    rreg(8'h20, r);
  endtask

  task automatic tnext();
    trig();
    if (!s)
      trig();
    `CHK(s, 1'b1)
  endtask

  initial
  begin
    reset = 1'b1;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    trigger = 1'b0;
    live_contact_flag = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i].we)
        wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, r);
      `CHK(r, rows[i].e)
    end
    #1;
    `CHK(core_power, 1'b0)
    `CHK(sample_periods, 5'd11)
    `CHK(startup_periods, 10'd80)
    `CHK(sequence_order_select, 1'b1)
    for (k = 0; k < 16; k++)
    begin
      wreg(8'h04, {12'h0, k[3:0], 16'h0010});
      #1;
      `CHK(startup_periods, sut[k][9:0])
    end
    wreg(8'h04, 32'h0000_0200);
    #1;
    c = converter_clock;
    p = 0;
    e = 0;
    for (k = 0; k < 100 && e < 2; k++)
    begin
      @(posedge clk);
      #1;
      if (converter_clock && !c)
      begin
        e++;
        p = k - p;
      end
      c = converter_clock;
    end
    `CHK(p, 6)
    wreg(8'h10, 32'h0000_0010);
    trig();
    `CHK(r, 32'h0000_02A5)
    wreg(8'h00, 32'h0000_0004);
    trig();
    `CHK(c, 1'b0)
    trig();
    `CHK(c, 1'b1)
    `CHK(r, 32'h0000_02A5)
    wreg(8'h04, 32'h0000_0210);
    wreg(8'h00, 32'h0000_0002);
    wreg(8'h00, 32'h0000_0004);
    wait_hi(1);
    @(posedge clk);
    trig();
    `CHK(c, 1'b1)
    `CHK(r, 32'h0000_00A9)
    wreg(8'h04, 32'h0000_0200);
    // ------
    // Protection, then the touch stream
    // ------
    wreg(8'hE4, 32'h1);
    foreach (prot[i])
    begin
      wreg(prot[i], 32'h0000_0010);
      rreg(8'hE8, r);
      `CHK(r, {16'h0, prot[i], 8'h01})
    end
    rreg(8'hE8, r);
    `CHK(r[0], 1'b0)
    rreg(8'h04, r);
    `CHK(r, 32'h0000_0200)
    wreg(8'hE4, 32'h0);
    wreg(8'h40, 32'h0100_0000);
    wreg(8'hB0, 32'h0100_0102);
    live_contact_flag <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      trig();
      sl[k] = s;
      `CHK(r, (s ? 32'h0000_3044 : 32'h0000_42A5))
    end
    `CHK(sl, (sl[0] ? 4'b0101 : 4'b1010))
    live_contact_flag <= 1'b0;
    tnext();
    `CHK(r, 32'h0)
    wreg(8'hB0, 32'h0000_0102);
    tnext();
    `CHK(r, 32'h0000_0044)
    wreg(8'h04, 32'h0B00_0030);
    wreg(8'hE4, 32'h1);
    wreg(8'h00, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(core_power, 1'b1)
    rreg(8'hE4, r);
    `CHK(r, 32'h0)
    rreg(8'hB0, r);
    `CHK(r, 32'h0)
    results();
  end
endmodule
`default_nettype wire

/* File: hw/adc_touch_buffer_and_regs.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adc_touch_params.svh"
module adc_touch_buffer_and_regs
  import adc_touch_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        trigger,
  input  wire logic        live_contact_flag,
  input  wire logic        result_valid,
  input  wire logic [1:0]  result_kind,
  input  wire logic [3:0]  result_chan,
  input  wire logic [9:0]  result_data,
  input  wire logic        seq_done,
  output logic             start_pulse,
  output logic             calib_run,
  output logic             touch_slot,
  output logic             resolution_select,
  output logic             core_power,
  output logic             sample_hold_time_field_x,
  output logic [4:0]       sample_periods,
  output logic             sequence_order_select,
  output logic [9:0]       startup_periods,
  output logic             converter_clock
);
  logic        soft_q;
  logic        rst;
  logic [31:0] mode_q;
  logic [31:0] seq1_q;
  logic [11:0] chan_q;
  logic [31:0] ext_q;
  logic [31:0] cwin_q;
  logic [31:0] analog_q;
  logic [31:0] tmode_q;
  logic [31:0] trig_q;
  logic        wp_en_q;
  logic        viol_q;
  logic [7:0]  viol_src_q;
  logic [15:0] last_q;
  logic [31:0] xpos_q;
  logic [31:0] ypos_q;
  logic [31:0] pres_q;
  logic [31:0] rdata_q;
  logic [6:0]  trig_cnt_q;
  logic        busy_q;
  logic [1:0]  cal_wait_q;
  logic        cal_pend_q;
  logic        calib_q;
  logic        start_q;
  logic        slot_q;
  logic        conv_clk_q;
  logic [9:0]  sup_q;
  logic [9:0]  sup_w;
  logic        blocked;
  logic        wr_ok;
  logic [15:0] touch_word;
  logic [3:0]  tag;
  logic [2:0]  repeat_set;
  logic [1:0]  avg_set;
  logic [6:0]  period_mask;
  logic [6:0]  slot_pos;
  logic [11:0] res_data;
  result_kind_e kind;

  clk_if cif ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_protected(input logic [7:0] a);
    is_protected = (a == `OFF_MODE) || (a == `OFF_SEQ1) || (a == `OFF_CH_SET) ||
                   (a == `OFF_CH_CLR) || (a == `OFF_EXT_MODE) || (a == `OFF_CMP_WIN) ||
                   (a == `OFF_ANALOG) || (a == `OFF_TOUCH_MODE) ||
                   (a == `OFF_TRIGGER);
  endfunction

  assign rst         = reset | soft_q;
  assign blocked     = wr && wp_en_q && is_protected(addr);
  assign wr_ok       = wr && !blocked;
  assign repeat_set  = tmode_q[`TS_REPEAT_LSB +: 3];
  assign avg_set     = tmode_q[`TS_AVG_LSB +: 2];
  assign period_mask = 7'((8'h01 << repeat_set) - 8'h01);
  assign slot_pos    = 7'(period_mask & ~7'((8'h01 << avg_set) - 8'h01));
  assign kind        = result_kind_e'(result_kind);

  // ----------------------------------------
  // Soft reset, one cycle
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      soft_q <= 1'b0;
    else
      soft_q <= wr && addr == `OFF_CONTROL && wdata[`CTL_SOFT_RESET];
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q   <= 32'h0000_0000;
      seq1_q   <= 32'h0000_0000;
      chan_q   <= 12'h000;
      ext_q    <= 32'h0000_0000;
      cwin_q   <= 32'h0000_0000;
      analog_q <= `ANALOG_RESET;
      tmode_q  <= 32'h0000_0000;
      trig_q   <= 32'h0000_0000;
      wp_en_q  <= 1'b0;
    end
    else if (wr_ok)
    begin
      unique case (addr)
        `OFF_MODE:       mode_q   <= wdata;
        `OFF_SEQ1:       seq1_q   <= {16'h0000, wdata[15:0]};
        `OFF_CH_SET:     chan_q   <= chan_q | wdata[11:0];
        `OFF_CH_CLR:     chan_q   <= chan_q & ~wdata[11:0];
        `OFF_EXT_MODE:   ext_q    <= wdata;
        `OFF_CMP_WIN:    cwin_q   <= wdata;
        `OFF_ANALOG:     analog_q <= wdata;
        `OFF_TOUCH_MODE: tmode_q  <= wdata;
        `OFF_TRIGGER:    trig_q   <= wdata;
        `OFF_WP_MODE:    wp_en_q  <= wdata[0];
        default:         ;
      endcase
    end
  end

  // ----------------------------------------
  // Write protection status
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      viol_q     <= 1'b0;
      viol_src_q <= 8'h00;
    end
    else if (blocked)
    begin
      viol_q     <= 1'b1;
      viol_src_q <= addr;
    end
    else if (rd && addr == `OFF_WP_STATUS)
    begin
      viol_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Trigger pattern and calibration scheduling
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      trig_cnt_q <= 7'h00;
      slot_q     <= 1'b0;
      busy_q     <= 1'b0;
      start_q    <= 1'b0;
    end
    else
    begin
      start_q <= (wr && addr == `OFF_CONTROL && wdata[`CTL_START]) || trigger;
      if (start_q)
      begin
        busy_q     <= 1'b1;
        trig_cnt_q <= (trig_cnt_q + 7'h01) & period_mask;
        slot_q     <= (tmode_q[1:0] != 2'b00) && (trig_cnt_q == slot_pos);
      end
      else if (seq_done)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_pend_q <= 1'b0;
      cal_wait_q <= 2'b00;
      calib_q    <= 1'b0;
    end
    else
    begin
      if (wr && addr == `OFF_CONTROL && wdata[`CTL_CALIBRATE])
      begin
        cal_pend_q <= 1'b1;
        cal_wait_q <= busy_q ? 2'b01 : 2'b10;
      end
      else if (start_q && cal_pend_q)
      begin
        if (cal_wait_q == 2'b01)
        begin
          cal_pend_q <= 1'b0;
          calib_q    <= 1'b1;
        end
        cal_wait_q <= cal_wait_q - 2'b01;
      end
      if (seq_done)
        calib_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Result shaping
  // ----------------------------------------
  always_comb
  begin
    res_data = mode_q[`MODE_RESOLUTION_SELECT] ? {4'h0, result_data[9:2]} : {2'b00, result_data};
    unique case (kind)
      res_x:       tag = tmode_q[`TS_CONTACT_EN] ? `TAG_X : 4'h0;
      res_y:       tag = tmode_q[`TS_CONTACT_EN] ? `TAG_Y : 4'h0;
      res_z:       tag = !tmode_q[`TS_CONTACT_EN] ? 4'h0 : result_chan[0] ? `TAG_Z2 : `TAG_Z1;
      res_classic: tag = result_chan;
    endcase
    touch_word = {ext_q[`EXT_TAG] ? tag : 4'h0, res_data};
    if (kind != res_classic && tmode_q[`TS_CONTACT_EN] && !live_contact_flag)
      touch_word = 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_q <= 16'h0000;
      xpos_q <= 32'h0000_0000;
      ypos_q <= 32'h0000_0000;
      pres_q <= 32'h0000_0000;
    end
    else if (result_valid && !calib_q)
    begin
      last_q <= touch_word;
      unique case (kind)
        res_x:   xpos_q[11:0] <= res_data;
        res_y:   ypos_q[11:0] <= res_data;
        res_z:   pres_q[{result_chan[0], 4'h0} +: 12] <= res_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !rd)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (addr)
        `OFF_MODE:       rdata_q <= mode_q;
        `OFF_SEQ1:       rdata_q <= seq1_q;
        `OFF_CH_STATE:   rdata_q <= {20'h00000, chan_q};
        `OFF_LAST:       rdata_q <= {16'h0000, last_q};
        `OFF_EXT_MODE:   rdata_q <= ext_q;
        `OFF_CMP_WIN:    rdata_q <= cwin_q;
        `OFF_ANALOG:     rdata_q <= analog_q;
        `OFF_TOUCH_MODE: rdata_q <= tmode_q;
        `OFF_TOUCH_X:    rdata_q <= xpos_q;
        `OFF_TOUCH_Y:    rdata_q <= ypos_q;
        `OFF_TOUCH_P:    rdata_q <= pres_q;
        `OFF_TRIGGER:    rdata_q <= trig_q;
        `OFF_WP_MODE:    rdata_q <= {31'h0, wp_en_q};
        `OFF_WP_STATUS:  rdata_q <= {16'h0000, viol_src_q, 7'h00, viol_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Core timing outputs
  // ----------------------------------------
  assign cif.presc = mode_q[`MODE_PRESC_LSB +: 8];
  converter_clock_div u_div
  (
    .clk   (clk),
    .reset (rst),
    .cif   (cif)
  );

  startup_lut u_lut
  (
    .code    (mode_q[`MODE_START_LSB +: 4]),
    .periods (sup_w)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_clk_q <= 1'b0;
      sup_q      <= 10'h000;
    end
    else
    begin
      if (cif.tick)
        conv_clk_q <= ~conv_clk_q;
      sup_q <= sup_w;
    end
  end

  // Power held on while busy so sleep never cuts a sequence short
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_power               <= 1'b1;
      sample_periods           <= 5'h01;
      resolution_select        <= 1'b0;
      sequence_order_select    <= 1'b0;
      sample_hold_time_field_x <= 1'b0;
    end
    else
    begin
      core_power               <= busy_q || !mode_q[`MODE_SLEEP];
      sample_periods           <= 5'(mode_q[`MODE_TRACK_LSB +: 4]) + 5'h01;
      resolution_select        <= mode_q[`MODE_RESOLUTION_SELECT];
      sequence_order_select    <= mode_q[`MODE_SEQ_ORDER];
    end
  end

  assign rdata           = rdata_q;
  assign start_pulse     = start_q;
  assign calib_run       = calib_q;
  assign touch_slot      = slot_q;
  assign startup_periods = sup_q;
  assign converter_clock = conv_clk_q;
endmodule
`default_nettype wire

/* File: hw/adc_touch_params.svh */
`ifndef ADC_TOUCH_PARAMS_SVH
`define ADC_TOUCH_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CONTROL      8'h00
`define OFF_MODE         8'h04
`define OFF_SEQ1         8'h08
`define OFF_CH_SET       8'h10
`define OFF_CH_CLR       8'h14
`define OFF_CH_STATE     8'h18
`define OFF_LAST         8'h20
`define OFF_IRQ_SET      8'h24
`define OFF_IRQ_CLR      8'h28
`define OFF_IRQ_MASK     8'h2C
`define OFF_IRQ_FLAGS    8'h30
`define OFF_OVERRUN      8'h3C
`define OFF_EXT_MODE     8'h40
`define OFF_CMP_WIN      8'h44
`define OFF_CH_RES0      8'h50
`define OFF_CH_RES11     8'h7C
`define OFF_ANALOG       8'h94
`define OFF_TOUCH_MODE   8'hB0
`define OFF_TOUCH_X      8'hB4
`define OFF_TOUCH_Y      8'hB8
`define OFF_TOUCH_P      8'hBC
`define OFF_TRIGGER      8'hC0
`define OFF_WP_MODE      8'hE4
`define OFF_WP_STATUS    8'hE8
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define ANALOG_RESET     32'h0000_0100
`define CTL_SOFT_RESET   0
`define CTL_START        1
`define CTL_CALIBRATE    2
`define MODE_RESOLUTION_SELECT      4
`define MODE_SLEEP       5
`define MODE_PRESC_LSB   8
`define MODE_START_LSB   16
`define MODE_TRACK_LSB   24
`define MODE_SEQ_ORDER   31
`define EXT_TAG          24
`define TS_MODE_LSB      0
`define TS_AVG_LSB       4
`define TS_REPEAT_LSB    8
`define TS_CONTACT_EN    24
`define WP_VIOL_FLAG     0
`define WP_SRC_LSB       8
`define TAG_X            4'h0
`define TAG_Y            4'h1
`define TAG_Z1           4'h2
`define TAG_Z2           4'h3
`define NUM_CH           12
`endif

/* File: hw/adc_touch_pkg.sv */
package adc_touch_pkg;
  typedef enum logic [1:0] {
    res_classic,
    res_x,
    res_y,
    res_z
  } result_kind_e;
endpackage

/* File: hw/clk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface clk_if;
  logic [7:0] presc;
  logic       tick;
  modport ctl (output presc, input tick);
  modport div (input presc, output tick);
endinterface
`default_nettype wire

/* File: hw/converter_clock_div.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_clock_div
(
  input wire logic clk,
  input wire logic reset,
  clk_if.div       cif
);
  logic [8:0] cnt_q;

  // ----------------------------------------
  // Tick every presc+1 cycles, two ticks a period
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset || cnt_q >= {1'b0, cif.presc})
    begin
      cnt_q <= 9'h000;
    end
    else
    begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  assign cif.tick = (cnt_q == {1'b0, cif.presc});
endmodule
`default_nettype wire

/* File: hw/startup_lut.sv */
`timescale 1ns/1ps
`default_nettype none
module startup_lut
(
  input  wire logic [3:0]  code,
  output logic      [9:0]  periods
);
  always_comb
  begin
    unique case (code)
      4'h0: periods = 10'h000;
      4'h1: periods = 10'h008;
      4'h2: periods = 10'h010;
      4'h3: periods = 10'h018;
      4'h4: periods = 10'h040;
      4'h5: periods = 10'h050;
      4'h6: periods = 10'h060;
      4'h7: periods = 10'h070;
      4'h8: periods = 10'h200;
      4'h9: periods = 10'h240;
      4'hA: periods = 10'h280;
      4'hB: periods = 10'h2C0;
      4'hC: periods = 10'h300;
      4'hD: periods = 10'h340;
      4'hE: periods = 10'h380;
      4'hF: periods = 10'h3C0;
    endcase
  end
endmodule
`default_nettype wire
